// File: design/pwm_generator_with_deadband.sv
/*
 pwm_generator_with_deadband: four pwm generators with counters, comparators,
 event-action signal generation, dead-band pairs, event selection for interrupt
 and adc trigger, and an output control stage, behind an axi4-lite slave.
 assumes: aclk, synchronous active-low aresetn; the bus master keeps axi rules.
*/
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module pwm_generator_with_deadband #(
	parameter int NUM_GEN = pwm_pkg::NUM_GEN,
	parameter int CNT_W   = pwm_pkg::CNT_W
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output var  logic [2*NUM_GEN-1:0] pwm_pins,
	output var  logic [NUM_GEN-1:0]   irq_pulse,
	output var  logic [NUM_GEN-1:0]   adc_trigger
);

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------
	function automatic logic apply_action(input logic cur, input logic [1:0] act);
		logic r;
		r = cur;
		unique case (act)
			pwm_pkg::ACT_NONE:   r = cur;
			pwm_pkg::ACT_TOGGLE: r = ~cur;
			pwm_pkg::ACT_LOW:    r = 1'b0;
			pwm_pkg::ACT_HIGH:   r = 1'b1;
		endcase
		return r;
	endfunction

	// zero/load first, then matches; later actions win like a priority chain
	function automatic logic run_events(input logic cur, input logic [11:0] acts,
		input logic [5:0] ev);
		logic r;
		r = cur;
		for (int e = 0; e < pwm_pkg::NUM_EVT; e++) begin
			if (ev[e]) begin
				r = apply_action(r, acts[e*pwm_pkg::ACT_W +: pwm_pkg::ACT_W]);
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	logic [31:0]             regs_reg [NUM_GEN][10];
	logic [2*NUM_GEN-1:0]    outen_reg;
	logic [2*NUM_GEN-1:0]    inv_reg;

	logic [11:0]             aw_addr_reg;
	logic                    aw_have_reg;
	logic [31:0]             w_data_reg;
	logic [3:0]              w_strb_reg;
	logic                    w_have_reg;

	// ------------------------------------------------------------------
	// generators
	// ------------------------------------------------------------------
	logic [CNT_W-1:0]        count_reg [NUM_GEN];
	logic [NUM_GEN-1:0]      dir_up_reg;
	logic [NUM_GEN-1:0]      sig_a_reg;
	logic [NUM_GEN-1:0]      sig_b_reg;
	logic [CNT_W-1:0]        rise_cnt_reg [NUM_GEN];
	logic [CNT_W-1:0]        fall_cnt_reg [NUM_GEN];
	logic [NUM_GEN-1:0]      db_hi_reg;
	logic [NUM_GEN-1:0]      db_lo_reg;
	logic [NUM_GEN-1:0]      sig_a_last_reg;
	logic [2*NUM_GEN-1:0]    raw_out;
	logic [5:0]              events [NUM_GEN];

	for (genvar g = 0; g < NUM_GEN; g++) begin : gen_blk
		wire logic [CNT_W-1:0] load_v  = regs_reg[g][pwm_pkg::OFS_LOAD][CNT_W-1:0];
		wire logic [CNT_W-1:0] cmpa_v  = regs_reg[g][pwm_pkg::OFS_CMPA][CNT_W-1:0];
		wire logic [CNT_W-1:0] cmpb_v  = regs_reg[g][pwm_pkg::OFS_CMPB][CNT_W-1:0];
		wire logic [31:0]      ctl_v   = regs_reg[g][pwm_pkg::OFS_CTL];
		wire logic [11:0]      gena_v  = regs_reg[g][pwm_pkg::OFS_GENA][11:0];
		wire logic [11:0]      genb_v  = regs_reg[g][pwm_pkg::OFS_GENB][11:0];
		wire logic [15:0]      evsel_v = regs_reg[g][pwm_pkg::OFS_EVSEL][15:0];
		wire logic             run     = ctl_v[pwm_pkg::CTL_RUN];
		wire logic             updown  = ctl_v[pwm_pkg::CTL_UPDOWN];
		wire logic             db_en   = ctl_v[pwm_pkg::CTL_DBEN];
		wire logic [CNT_W-1:0] cnt     = count_reg[g];
		wire logic             up_dir  = updown & dir_up_reg[g];
		wire logic             ev_zero = run & (cnt == '0);
		wire logic             ev_load = run & (cnt == load_v);
		// matching value above load is unreachable, so no pulse
		wire logic             ma      = run & (cmpa_v <= load_v) & (cnt == cmpa_v);
		wire logic             mb      = run & (cmpb_v <= load_v) & (cnt == cmpb_v);
		wire logic             no_mt   = ~(ev_zero | ev_load);
		// up events only exist in up/down mode
		wire logic [5:0]       ev      = {mb & ~up_dir & no_mt, mb & up_dir & no_mt,
			ma & ~up_dir & no_mt, ma & up_dir & no_mt, ev_load, ev_zero};
		wire logic             irq_n   = |(ev & evsel_v[5:0]);
		wire logic             adc_n   = |(ev & evsel_v[pwm_pkg::EVSEL_ADC +: 6]);
		// a sees zero, load and a-events; b sees zero, load and b-events
		wire logic [11:0]      gena_m  = gena_v & 12'h0_0FF;
		wire logic [11:0]      genb_m  = genb_v & 12'h0_F0F;
		wire logic             a_next  = run_events(sig_a_reg[g], gena_m, ev);
		wire logic             b_next  = run_events(sig_b_reg[g], genb_m, ev);
		wire logic             a_rise  = sig_a_reg[g] & ~sig_a_last_reg[g];
		wire logic             a_fall  = ~sig_a_reg[g] & sig_a_last_reg[g];

		assign events[g] = ev;
		// dead-band off passes both; on drives the delayed pair
		assign raw_out[2*g]   = db_en ? db_hi_reg[g] : sig_a_reg[g];
		assign raw_out[2*g+1] = db_en ? db_lo_reg[g] : sig_b_reg[g];

		always_ff @(posedge aclk) begin
			if (!aresetn || !run) begin
				count_reg[g]  <= '0;
				dir_up_reg[g] <= 1'b1;
			end else if (!updown) begin
				dir_up_reg[g] <= 1'b0;
				count_reg[g]  <= (cnt == '0) ? load_v : cnt - 1'b1;
			end else if (dir_up_reg[g]) begin
				count_reg[g]  <= (cnt >= load_v) ? cnt - 1'b1 : cnt + 1'b1;
				dir_up_reg[g] <= (cnt < load_v) && (cnt + 1'b1 != load_v);
			end else begin
				count_reg[g]  <= (cnt == '0) ? cnt + 1'b1 : cnt - 1'b1;
				dir_up_reg[g] <= (cnt == '0) || (cnt == 16'h0001);
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sig_a_reg[g]      <= 1'b0;
				sig_b_reg[g]      <= 1'b0;
				sig_a_last_reg[g] <= 1'b0;
				irq_pulse[g]      <= 1'b0;
				adc_trigger[g]    <= 1'b0;
			end else begin
				sig_a_reg[g]      <= a_next;
				sig_b_reg[g]      <= b_next;
				sig_a_last_reg[g] <= sig_a_reg[g];
				irq_pulse[g]      <= irq_n;
				adc_trigger[g]    <= adc_n;
			end
		end

		// each edge reloads its counter; output rises when the count expires
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rise_cnt_reg[g] <= '0;
				fall_cnt_reg[g] <= '0;
				db_hi_reg[g]    <= 1'b0;
				db_lo_reg[g]    <= 1'b0;
			end else if (a_rise) begin
				db_lo_reg[g]    <= 1'b0;
				rise_cnt_reg[g] <= regs_reg[g][pwm_pkg::OFS_DBRISE][CNT_W-1:0];
				db_hi_reg[g]    <= 1'b0;
			end else if (a_fall) begin
				db_hi_reg[g]    <= 1'b0;
				fall_cnt_reg[g] <= regs_reg[g][pwm_pkg::OFS_DBFALL][CNT_W-1:0];
				db_lo_reg[g]    <= 1'b0;
			end else if (sig_a_reg[g]) begin
				if (rise_cnt_reg[g] != '0) begin
					rise_cnt_reg[g] <= rise_cnt_reg[g] - 1'b1;
				end else begin
					db_hi_reg[g] <= 1'b1;
				end
			end else begin
				if (fall_cnt_reg[g] != '0) begin
					fall_cnt_reg[g] <= fall_cnt_reg[g] - 1'b1;
				end else begin
					db_lo_reg[g] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// output control
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_pins <= '0;
		end else begin
			pwm_pins <= (raw_out & outen_reg) ^ inv_reg;
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite write
	// ------------------------------------------------------------------
	wire logic        aw_take  = s_axi_awvalid & s_axi_awready;
	wire logic        w_take   = s_axi_wvalid & s_axi_wready;
	wire logic        do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	wire logic [11:0] wa       = aw_addr_reg;
	wire logic [11:0] wa_rel   = wa - pwm_pkg::GEN_BASE;
	wire logic [1:0]  w_gen    = wa_rel[7:6];
	wire logic [3:0]  w_ofs    = wa_rel[5:2];
	wire logic        w_in_gen = (wa >= pwm_pkg::GEN_BASE) && (wa_rel[11:8] == 4'h0) &&
		(w_ofs < pwm_pkg::OFS_STAT) && (wa[1:0] == 2'b00);
	wire logic        w_outen  = wa == pwm_pkg::ADDR_OUTEN;
	wire logic        w_inv    = wa == pwm_pkg::ADDR_INV;
	wire logic        w_ok     = w_in_gen | w_outen | w_inv;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= pwm_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_reg   <= s_axi_awaddr;
				aw_have_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				w_have_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_ok ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			outen_reg <= '0;
			inv_reg   <= '0;
			for (int g = 0; g < NUM_GEN; g++) begin
				for (int r = 0; r < 10; r++) begin
					regs_reg[g][r] <= pwm_pkg::RESET_WORD;
				end
			end
		end else if (do_write) begin
			if (w_in_gen) begin
				regs_reg[w_gen][w_ofs] <= merge_word(regs_reg[w_gen][w_ofs], w_data_reg,
					w_strb_reg);
			end
			if (w_outen) begin
				outen_reg <= w_strb_reg[0] ? w_data_reg[2*NUM_GEN-1:0] : outen_reg;
			end
			if (w_inv) begin
				inv_reg <= w_strb_reg[0] ? w_data_reg[2*NUM_GEN-1:0] : inv_reg;
			end
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite read
	// ------------------------------------------------------------------
	wire logic [11:0] ra       = s_axi_araddr;
	wire logic [11:0] ra_rel   = ra - pwm_pkg::GEN_BASE;
	wire logic [1:0]  r_gen    = ra_rel[7:6];
	wire logic [3:0]  r_ofs    = ra_rel[5:2];
	wire logic        r_in_gen = (ra >= pwm_pkg::GEN_BASE) && (ra_rel[11:8] == 4'h0) &&
		(r_ofs <= pwm_pkg::OFS_STAT) && (ra[1:0] == 2'b00);
	wire logic [31:0] stat_w   = {7'h00, dir_up_reg[r_gen], sig_b_reg[r_gen],
		sig_a_reg[r_gen], 6'h00, count_reg[r_gen]};
	wire logic [31:0] gen_rd   = (r_ofs == pwm_pkg::OFS_STAT) ? stat_w : regs_reg[r_gen][r_ofs];
	wire logic        r_ok     = r_in_gen || ra == pwm_pkg::ADDR_OUTEN ||
		ra == pwm_pkg::ADDR_INV || ra == pwm_pkg::ADDR_PINS;
	wire logic [31:0] rd_word  = r_in_gen ? gen_rd :
		(ra == pwm_pkg::ADDR_OUTEN) ? {24'h00_0000, outen_reg} :
		(ra == pwm_pkg::ADDR_INV)   ? {24'h00_0000, inv_reg} :
		(ra == pwm_pkg::ADDR_PINS)  ? {24'h00_0000, pwm_pins} : pwm_pkg::RESET_WORD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= pwm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= r_ok ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// File: design/pwm_pkg.sv
/*
 pwm_pkg: constants, field layouts and a carrier struct for the four-generator
 pwm block with dead-band stage and axi4-lite register access.
 assumes: a single system clock; one 32-bit aligned word per register.
*/
package pwm_pkg;

	localparam int NUM_GEN    = 4;
	localparam int CNT_W      = 16;
	localparam int NUM_EVT    = 6;
	localparam int NUM_OUT    = 2 * NUM_GEN;

	// generator page base and stride, then register word offsets within a page
	localparam logic [11:0] GEN_BASE   = 12'h040;
	localparam logic [11:0] GEN_STRIDE = 12'h040;
	localparam logic [3:0]  OFS_CTL    = 4'h0;
	localparam logic [3:0]  OFS_LOAD   = 4'h1;
	localparam logic [3:0]  OFS_CMPA   = 4'h2;
	localparam logic [3:0]  OFS_CMPB   = 4'h3;
	localparam logic [3:0]  OFS_GENA   = 4'h4;
	localparam logic [3:0]  OFS_GENB   = 4'h5;
	localparam logic [3:0]  OFS_DBRISE = 4'h6;
	localparam logic [3:0]  OFS_DBFALL = 4'h7;
	localparam logic [3:0]  OFS_EVSEL  = 4'h8;
	localparam logic [3:0]  OFS_STAT   = 4'h9;
	// module-level registers
	localparam logic [11:0] ADDR_OUTEN = 12'h000;
	localparam logic [11:0] ADDR_INV   = 12'h004;
	localparam logic [11:0] ADDR_PINS  = 12'h008;

	// control register bits
	localparam int CTL_RUN    = 0;
	localparam int CTL_UPDOWN = 1;
	localparam int CTL_DBEN   = 2;
	// event indices, each action field is two bits at 2*index
	localparam int EV_ZERO  = 0;
	localparam int EV_LOAD  = 1;
	localparam int EV_AUP   = 2;
	localparam int EV_ADN   = 3;
	localparam int EV_BUP   = 4;
	localparam int EV_BDN   = 5;
	localparam int ACT_W    = 2;
	// event select: interrupt set low byte, adc set next byte
	localparam int EVSEL_ADC = 8;

	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW    = 2'h2;
	localparam logic [1:0] ACT_HIGH   = 2'h3;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY  = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [CNT_W-1:0] dbfall;
		logic [CNT_W-1:0] dbrise;
		logic [11:0]      gen_b;
		logic [11:0]      gen_a;
		logic [CNT_W-1:0] cmp_b;
		logic [CNT_W-1:0] cmp_a;
		logic [CNT_W-1:0] load;
		logic [2:0]       ctl;
		logic [15:0]      evsel;
	} gen_cfg_type;

endpackage

// File: testbench/gate_driver_model.sv
/*
 gate_driver_model: gate-driver and adc-input side of the pwm pins; flags any
 pair driven high together and counts adc trigger pulses.
 assumes: sampled on the block's clock; clear is synchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module gate_driver_model #(
	parameter int NUM_GEN = 4
) (
	input  wire logic                 aclk,
	input  wire logic                 clear,
	input  wire logic [2*NUM_GEN-1:0] pins,
	input  wire logic [NUM_GEN-1:0]   adc_in,
	output var  logic [NUM_GEN-1:0]   overlap,
	output var  logic [31:0]          adc_count
);
	// ------------------------------
	// shoot-through watch and trigger count
	// ------------------------------
	always_ff @(posedge aclk) begin
		if (clear) begin
			overlap   <= '0;
			adc_count <= '0;
		end else begin
			for (int g = 0; g < NUM_GEN; g++) begin
				if (pins[2*g] && pins[2*g+1]) begin
					overlap[g] <= 1'b1;
				end
			end
			adc_count <= adc_count + 32'($countones(adc_in));
		end
	end
endmodule

`default_nettype wire

// File: testbench/pwm_checker_assertions.sv
/*
 pwm_checker_assertions: reset and bus handshake checks at the pwm block's ports.
 assumes: bound to pwm_generator_with_deadband; one clock, sync active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module pwm_checker_assertions #(
	parameter int NUM_GEN = pwm_pkg::NUM_GEN
) (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic                 s_axi_wvalid,
	input wire logic                 s_axi_wready,
	input wire logic [1:0]           s_axi_bresp,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic [2*NUM_GEN-1:0] pwm_pins,
	input wire logic [NUM_GEN-1:0]   irq_pulse,
	input wire logic [NUM_GEN-1:0]   adc_trigger
);
	// ------------------------------
	// properties
	// ------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_RESET_IDLE:
		assert property ($rose(aresetn) |-> pwm_pins == '0 && irq_pulse == '0 && adc_trigger == '0)
		else $error("outputs not idle after reset");
	AST_B_ANSWER:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid) else $error("write response late");
	AST_R_ANSWER:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_B_STANDS:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_STANDS:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_W_REFUSED:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_R_REFUSED:
		assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	AST_B_RELEASE:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
			&& s_axi_wready) else $error("write channel not freed");
	AST_R_RELEASE:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not freed");
endmodule

bind pwm_generator_with_deadband pwm_checker_assertions #(.NUM_GEN(NUM_GEN)) i_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwm_pins(pwm_pins),
	.irq_pulse(irq_pulse), .adc_trigger(adc_trigger)
);

`default_nettype wire

// File: testbench/testbench.sv
/*
 testbench: random and corner-case runs of the pwm block over axi4-lite.
 assumes: pwm_pkg, the design, the checker and gate_driver_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0, clear = 1'b1;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, seed = 32'h3dc9_77ac, rd, rdata, adc_count;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  pins;
	logic [3:0]  irq, adc, overlap;
	int          errors = 0, total_checks = 0, n_irq, n_adc, hi0, hi1, t_irq, t_adc, stall = 0;

	always #20 aclk = ~aclk;

	pwm_generator_with_deadband i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pwm_pins(pins), .irq_pulse(irq), .adc_trigger(adc)
	);
	gate_driver_model i_drv (.aclk(aclk), .clear(clear), .pins(pins), .adc_in(adc),
		.overlap(overlap), .adc_count(adc_count));

	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] ga(input int g, input logic [3:0] o);
		return pwm_pkg::GEN_BASE + pwm_pkg::GEN_STRIDE * 12'(g) + {6'h00, o, 2'b00};
	endfunction
	function automatic logic [31:0] act(input int ev, input logic [1:0] code);
		return {30'h0000_0000, code} << (pwm_pkg::ACT_W * ev);
	endfunction
	function automatic logic [31:0] bit_at(input int n);
		return 32'h0000_0001 << n;
	endfunction
	task pick(input int lo, input int span, output int v);
		seed = lfsr(seed);
		v = lo + int'(seed % 32'(span));
	endtask
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task end_test(input string s);
		$display("test %s done, mismatches so far %0d", s, errors);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------
	// bus master and configuration
	// ------------------------------
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		awaddr <= a; araddr <= a; wdata <= d;
		awvalid <= w; wvalid <= w; arvalid <= !w;
		bready <= w && stall == 0; rready <= !w && stall == 0;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if ((bready && bvalid) || (rready && rvalid)) begin
				q = rdata;
				r = w ? bresp : rresp;
				break;
			end
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
			bready <= w && n + 1 >= stall;
			rready <= !w && n + 1 >= stall;
		end
		if (n == 50) begin
			errors++;
			$display("Error bus reply expected response seen none");
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, rd, rs);
		check_resp("write response", pwm_pkg::RESP_OKAY, rs);
	endtask
	// words for ctl(stopped), load, cmp a, cmp b, action a, action b, rise, fall, select
	task cfg(input int g, input logic [2:0] ctl, input int ld, input int ca, input int cb,
		input logic [31:0] xa, input logic [31:0] xb, input logic [31:0] ev, input int db);
		logic [31:0] v [0:8];
		v = '{32'h0000_0000, 32'(ld), 32'(ca), 32'(cb), xa, xb, 32'(db), 32'(db), ev};
		for (int o = 0; o < 9; o++) wr(ga(g, 4'(o)), v[o]);
		wr(ga(g, pwm_pkg::OFS_CTL), {29'h0000_0000, ctl});
	endtask
	task watch(input int g, input int n);
		n_irq = 0; n_adc = 0; hi0 = 0; hi1 = 0; t_irq = -1; t_adc = -1;
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			if (irq[g] === 1'b1) begin n_irq++; if (t_irq < 0) t_irq = i; end
			if (adc[g] === 1'b1) begin n_adc++; if (t_adc < 0) t_adc = i; end
			if (pins[2*g] === 1'b1) hi0++;
			if (pins[2*g+1] === 1'b1) hi1++;
		end
	endtask

	// ------------------------------
	// tests
	// ------------------------------
	initial begin
		int g, L, m, P, d;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		clear <= 1'b0;
		@(posedge aclk);
		xfer(1'b0, ga(0, pwm_pkg::OFS_LOAD), '0, rd, rs);
		check("load reset", pwm_pkg::RESET_WORD, rd);
		xfer(1'b0, pwm_pkg::ADDR_PINS, '0, rd, rs);
		check("pins reset", pwm_pkg::RESET_WORD, rd);
		stall = 3;
		xfer(1'b1, 12'h3f0, 32'h1234_5678, rd, rs);
		check_resp("unmapped write", pwm_pkg::RESP_SLVERR, rs);
		xfer(1'b0, 12'h3f0, '0, rd, rs);
		stall = 0;
		check_resp("unmapped read", pwm_pkg::RESP_SLVERR, rs);
		end_test("registers");
		for (int k = 0; k < 4; k++) begin
			pick(0, 4, g); pick(4, 8, L); pick(1, L - 1, m); pick(1, 2, d);
			P = L + 1;
			wr(pwm_pkg::ADDR_OUTEN, 32'h0000_00ff);
			wr(pwm_pkg::ADDR_INV, '0);
			cfg(g, 3'b001, L, m, L + 3, act(0, 2'h3) | act(3, 2'h2) | act(5, 2'h3),
				act(0, 2'h2) | act(5, 2'h3), bit_at(0) | bit_at(pwm_pkg::EVSEL_ADC + 3), 0);
			watch(g, 2 * P); watch(g, 3 * P);
			check("irq count", 3, n_irq);
			check("adc count", 3, n_adc);
			check("match offset", L - m + 1, (t_adc - t_irq + P) % P);
			check("first high", 3 * (L - m + 1), hi0);
			check("second high", 0, hi1);
			xfer(1'b0, ga(g, pwm_pkg::OFS_STAT), '0, rd, rs);
			check("direction", 0, 32'(rd[24]));
			cfg(g, 3'b001, L, m, m, act(0, 2'h3) | act(3, 2'h2) | act(5, 2'h3),
				act(0, 2'h2) | act(3, 2'h2) | act(5, 2'h3), bit_at(0) | bit_at(9), 0);
			watch(g, 2 * P); watch(g, 3 * P);
			check("load offset", 1, (t_adc - t_irq + P) % P);
			check("first high", 3 * (L - m + 1), hi0);
			check("second high", 3 * m, hi1);
			wr(pwm_pkg::ADDR_OUTEN, bit_at(2 * g));
			wr(pwm_pkg::ADDR_INV, bit_at(2 * g) | bit_at(2 * g + 1));
			cfg(g, 3'b001, L, 0, 0, act(0, 2'h1) | act(3, 2'h1), act(0, 2'h3), 0, 0);
			watch(g, 2 * P); watch(g, 2 * P);
			check("toggle high", P, hi0);
			check("masked inverted", 2 * P, hi1);
			wr(pwm_pkg::ADDR_OUTEN, 32'h0000_00ff);
			wr(pwm_pkg::ADDR_INV, '0);
			P = 2 * L;
			cfg(g, 3'b011, L, m, L + 1, act(2, 2'h3) | act(3, 2'h2), act(0, 2'h2) | act(4, 2'h3),
				bit_at(2) | bit_at(pwm_pkg::EVSEL_ADC + 3), 0);
			watch(g, 2 * P); watch(g, 3 * P);
			check("updown irq", 3, n_irq);
			check("updown offset", 2 * L - 2 * m, (t_adc - t_irq + P) % P);
			check("centered high", 3 * (2 * L - 2 * m), hi0);
			check("second high", 0, hi1);
			P = L + 1;
			cfg(g, 3'b101, L, m, m, act(0, 2'h3) | act(3, 2'h2), act(0, 2'h3),
				bit_at(pwm_pkg::EVSEL_ADC), d);
			watch(g, 2 * P);
			clear <= 1'b1;
			@(posedge aclk);
			clear <= 1'b0;
			watch(g, 3 * P);
			@(negedge aclk);
			check("pair overlap", 0, 32'(overlap[g]));
			check("raw trigger", 3, n_adc);
			check("model triggers", 32'(n_adc), adc_count);
			check("rise delayed", 1, 32'(hi0 < 3 * (L - m + 1)));
			check("gap present", 1, 32'(hi0 + hi1 < 3 * P));
			check("complement", 1, 32'(hi1 <= 3 * m));
			wr(ga(g, pwm_pkg::OFS_CTL), '0);
			end_test("trial");
		end
		conclude;
	end

	initial begin
		#(40 * 30000);
		errors++;
		$display("Error watchdog expected finish seen timeout");
		conclude;
	end
endmodule

`default_nettype wire
